// ### core/decode_map.vh
// constants for the instruction decode and cycle timing block
`ifndef DECODE_MAP_VH
`define DECODE_MAP_VH
`define OFF_CTRL 12'h000
`define OFF_BANK 12'h004
`define OFF_TPTR 12'h008
`define OFF_STAT 12'h00C
`define OFF_COUNT 12'h010
`define CTRL_RUN 0
`define CTRL_EXT 1
`define CTRL_RESET 2'h3
`define BANK_RESET 4'h0
`define TPTR_RESET 21'h00_0000
`define ACCESS_BANK 4'h0
`define PHASES 3'h4
`define WORD_W 16
`define TPTR_W 21
`define FLD_DEST 9
`define FLD_ACC 8
`define NIB_CONT 4'hF
`define NIB_EXT 4'hE
`define NIB_CTRL 4'hD
`define NIB_DWORD 4'hC
`define CL_NOP 3'h0
`define CL_BYTE 3'h1
`define CL_BIT 3'h2
`define CL_LIT 3'h3
`define CL_CTRL 3'h4
`define CL_DWORD 3'h5
`define CL_EXT 3'h6
`define BYTE_SKIP_OP 4'hF
`define DW_BRANCH 2'h3
`define C_BRA 4'h1
`define C_BCOND 4'h2
`define C_CALL 4'h3
`define C_RET 4'h4
`define C_TRD 4'h5
`define C_TWR 4'h6
`define TM_NONE 2'h0
`define TM_POSTINC 2'h1
`define TM_POSTDEC 2'h2
`define TM_PREINC 2'h3
`endif

// ### core/instr_decode_timing.v
// instruction word decoder with instruction cycle sequencing and apb registers
`timescale 1ns/10ps
`default_nettype none
`include "decode_map.vh"
module instr_decode_timing (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] instr_word,
  input wire instr_valid,
  input wire cond_true,
  output reg fetch_req,
  output reg issue,
  output reg second_word,
  output reg nop_slot,
  output reg cycle_strobe,
  output reg [1:0] q_phase,
  output reg [2:0] instr_class,
  output reg [5:0] base_opcode,
  output reg [2:0] ext_opcode,
  output reg dest_file,
  output reg [11:0] data_addr,
  output reg [2:0] bit_sel,
  output reg [7:0] literal,
  output reg [7:0] branch_offset,
  output reg [23:0] dw_payload,
  output reg [1:0] cost,
  output reg shadow_save,
  output reg shadow_restore,
  output reg table_access,
  output reg table_write,
  output reg [20:0] table_addr
);
  localparam S_RUN = 3'b001;
  localparam S_SECOND = 3'b010;
  localparam S_NOP = 3'b100;

  reg [2:0] state_r;
  reg [1:0] phase_r;
  reg [1:0] rem_r;
  reg [1:0] ctrl_r;
  reg [3:0] bank_selector_r;
  reg [20:0] table_pointer_r;
  reg [15:0] count_r;
  reg [11:0] dw_low_r;
  reg dw_branch_r;
  reg pend_cond_r;

  // decoded fields of the word on instr_word
  reg [2:0] class_nxt;
  reg [5:0] op_nxt;
  reg [2:0] ext_nxt;
  reg dest_nxt;
  reg [11:0] addr_nxt;
  reg [2:0] bit_nxt;
  reg [1:0] cost_nxt;
  reg save_nxt;
  reg restore_nxt;
  reg tbl_nxt;
  reg twr_nxt;
  reg [20:0] taddr_nxt;
  reg [20:0] tptr_nxt;
  reg [3:0] sub;

  wire [3:0] nib = instr_word[15:12];
  wire [20:0] tp_inc = table_pointer_r + 21'h00_0001;
  wire [20:0] tp_dec = table_pointer_r - 21'h00_0001;
  wire [3:0] bank_eff = instr_word[`FLD_ACC] ? bank_selector_r : `ACCESS_BANK;
  wire boundary = clk_en && (phase_r == 2'h3);
  wire running = ctrl_r[`CTRL_RUN];

  // apb slave, one wait state so read data is registered
  // decoded up here since the core process takes table pointer writes
  wire apb_set = psel && penable && !pready;
  wire apb_wr = apb_set && pwrite && clk_en;
  wire mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_BANK) || (paddr == `OFF_TPTR) ||
                (paddr == `OFF_STAT) || (paddr == `OFF_COUNT);
  reg [31:0] rd_nxt;

  always @* begin
    class_nxt = `CL_NOP;
    op_nxt = 6'h00;
    ext_nxt = 3'h0;
    dest_nxt = 1'b0;
    addr_nxt = {bank_eff, instr_word[7:0]};
    bit_nxt = 3'h0;
    cost_nxt = 2'h1;
    save_nxt = 1'b0;
    restore_nxt = 1'b0;
    tbl_nxt = 1'b0;
    twr_nxt = 1'b0;
    taddr_nxt = table_pointer_r;
    tptr_nxt = table_pointer_r;
    sub = instr_word[11:8];
    // top bits pick the format, the rest are operands
    if (instr_word[15:14] == 2'b00) begin
      class_nxt = `CL_BYTE;
      op_nxt = {2'b00, instr_word[13:10]};
      dest_nxt = instr_word[`FLD_DEST];
      if (instr_word[13:10] == `BYTE_SKIP_OP && cond_true) begin
        cost_nxt = 2'h2;
      end
    end else if (instr_word[15:14] == 2'b01) begin
      class_nxt = `CL_BIT;
      op_nxt = {4'h0, instr_word[13:12]};
      bit_nxt = instr_word[11:9];
      dest_nxt = 1'b1;
      // bit tests skip the next word when true
      if (instr_word[13] && cond_true) begin
        cost_nxt = 2'h2;
      end
    end else if (nib[3:2] == 2'b10) begin
      class_nxt = `CL_LIT;
      op_nxt = {2'b00, instr_word[13:10]};
    end else if (nib == `NIB_DWORD) begin
      class_nxt = `CL_DWORD;
      op_nxt = {4'h0, instr_word[11:10]};
      cost_nxt = 2'h2;
      if (instr_word[11:10] == `DW_BRANCH && cond_true) begin
        cost_nxt = 2'h3;
      end
    end else if (nib == `NIB_CTRL) begin
      class_nxt = `CL_CTRL;
      op_nxt = {2'b00, sub};
      case (sub)
        `C_BRA: begin
          cost_nxt = 2'h2;
        end
        `C_BCOND: begin
          if (cond_true) begin
            cost_nxt = 2'h2;
          end
        end
        `C_CALL: begin
          cost_nxt = 2'h2;
          save_nxt = instr_word[0];
        end
        `C_RET: begin
          cost_nxt = 2'h2;
          restore_nxt = instr_word[0];
        end
        `C_TRD, `C_TWR: begin
          tbl_nxt = 1'b1;
          twr_nxt = (sub == `C_TWR);
          // pointer mode in the two low bits
          case (instr_word[1:0])
            `TM_POSTINC: begin
              tptr_nxt = tp_inc;
            end
            `TM_POSTDEC: begin
              tptr_nxt = tp_dec;
            end
            `TM_PREINC: begin
              taddr_nxt = tp_inc;
              tptr_nxt = tp_inc;
            end
            default: begin
              tptr_nxt = table_pointer_r;
            end
          endcase
        end
        default: begin
          cost_nxt = 2'h1;
        end
      endcase
    end else if (nib == `NIB_EXT) begin
      // extended set off means the word runs as a nop
      if (ctrl_r[`CTRL_EXT]) begin
        class_nxt = `CL_EXT;
        ext_nxt = instr_word[10:8];
      end
    end else begin
      class_nxt = `CL_NOP;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_RUN;
      phase_r <= 2'h0;
      rem_r <= 2'h0;
      table_pointer_r <= `TPTR_RESET;
      count_r <= 16'h0000;
      dw_low_r <= 12'h000;
      dw_branch_r <= 1'b0;
      pend_cond_r <= 1'b0;
      fetch_req <= 1'b0;
      issue <= 1'b0;
      second_word <= 1'b0;
      nop_slot <= 1'b0;
      cycle_strobe <= 1'b0;
      q_phase <= 2'h0;
      instr_class <= `CL_NOP;
      base_opcode <= 6'h00;
      ext_opcode <= 3'h0;
      dest_file <= 1'b0;
      data_addr <= 12'h000;
      bit_sel <= 3'h0;
      literal <= 8'h00;
      branch_offset <= 8'h00;
      dw_payload <= 24'h00_0000;
      cost <= 2'h0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      table_access <= 1'b0;
      table_write <= 1'b0;
      table_addr <= 21'h00_0000;
    end else if (clk_en) begin
      phase_r <= phase_r + 2'h1;
      q_phase <= phase_r;
      cycle_strobe <= boundary;
      issue <= 1'b0;
      second_word <= 1'b0;
      nop_slot <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      table_access <= 1'b0;
      // no fetch while an inserted nop cycle runs
      fetch_req <= running && (state_r != S_NOP);
      // a table op in the same cycle overrides this write
      if (apb_wr && paddr == `OFF_TPTR) begin
        table_pointer_r <= pwdata[20:0];
      end
      if (boundary && running) begin
        case (state_r)
          S_RUN: begin
            if (instr_valid) begin
              issue <= 1'b1;
              count_r <= count_r + 16'h0001;
              instr_class <= class_nxt;
              base_opcode <= op_nxt;
              ext_opcode <= ext_nxt;
              dest_file <= dest_nxt;
              data_addr <= addr_nxt;
              bit_sel <= bit_nxt;
              literal <= instr_word[7:0];
              branch_offset <= instr_word[7:0];
              cost <= cost_nxt;
              shadow_save <= save_nxt;
              shadow_restore <= restore_nxt;
              table_access <= tbl_nxt;
              table_write <= twr_nxt;
              table_addr <= taddr_nxt;
              if (tbl_nxt) begin
                table_pointer_r <= tptr_nxt;
              end
              if (class_nxt == `CL_DWORD) begin
                dw_low_r <= instr_word[11:0];
                dw_branch_r <= (cost_nxt == 2'h3);
                state_r <= S_SECOND;
              end else if (cost_nxt != 2'h1) begin
                rem_r <= cost_nxt - 2'h1;
                state_r <= S_NOP;
              end
            end
          end
          S_SECOND: begin
            // a second word is consumed here, never decoded alone
            if (instr_valid) begin
              second_word <= 1'b1;
              dw_payload <= {dw_low_r, instr_word[11:0]};
              pend_cond_r <= (instr_word[15:12] != `NIB_CONT);
              if (dw_branch_r) begin
                rem_r <= 2'h1;
                state_r <= S_NOP;
              end else begin
                state_r <= S_RUN;
              end
            end
          end
          S_NOP: begin
            // nop slots ignore instr_valid, nothing is fetched
            nop_slot <= 1'b1;
            rem_r <= rem_r - 2'h1;
            if (rem_r == 2'h1) begin
              state_r <= S_RUN;
            end
          end
          default: begin
            state_r <= S_RUN;
          end
        endcase
      end
    end
  end

  // register read mux, unmapped offsets read as zero

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL: begin
        rd_nxt = {30'h0000_0000, ctrl_r};
      end
      `OFF_BANK: begin
        rd_nxt = {28'h000_0000, bank_selector_r};
      end
      `OFF_TPTR: begin
        rd_nxt = {11'h000, table_pointer_r};
      end
      `OFF_STAT: begin
        rd_nxt = {24'h00_0000, pend_cond_r, cost, state_r, phase_r};
      end
      `OFF_COUNT: begin
        rd_nxt = {16'h0000, count_r};
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
      bank_selector_r <= `BANK_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= apb_set;
      // writes to read-only offsets drop silently, no error
      pslverr <= apb_set && !mapped;
      // read data is zero outside the answer cycle
      prdata <= (apb_set && !pwrite) ? rd_nxt : 32'h0000_0000;
      if (apb_wr && paddr == `OFF_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
      if (apb_wr && paddr == `OFF_BANK) begin
        bank_selector_r <= pwdata[3:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/instr_decode_timing_sva.sv
// assertion checker for the instruction decode and timing block
`timescale 1ns/10ps
`default_nettype none
module instr_decode_timing_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] instr_word,
  input wire logic issue,
  input wire logic fetch_req,
  input wire logic [1:0] q_phase,
  input wire logic shadow_save,
  input wire logic second_word,
  input wire logic nop_slot,
  input wire logic cycle_strobe,
  input wire logic [2:0] instr_class,
  input wire logic dest_file,
  input wire logic [11:0] data_addr,
  input wire logic [2:0] bit_sel,
  input wire logic [1:0] cost
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one wait state, answer lasts one cycle
  apb_wait_state_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  apb_error_map_a: assert property (pready |-> pslverr == (paddr > 12'h010 || paddr[1:0] != 2'h0))
    else $error("slave error does not match address map");
  strobe_period_a: assert property (
    cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe) else $error("cycle strobe period wrong");
  byte_dest_a: assert property (
    issue && instr_class == 3'h1 |-> dest_file == $past(instr_word[9])) else $error("byte dest wrong");
  bit_select_a: assert property (
    issue && instr_class == 3'h2 |-> bit_sel == $past(instr_word[11:9])) else $error("bit select wrong");
  access_bank_a: assert property (
    issue && instr_class inside {3'h1, 3'h2} && !$past(instr_word[8])
    |-> data_addr == {4'h0, $past(instr_word[7:0])}) else $error("access bank address wrong");
  lone_cont_nop_a: assert property (
    issue && $past(instr_word[15:12]) == 4'hF |-> instr_class == 3'h0) else $error("lone word not nop");
  double_pair_a: assert property (
    issue && instr_class == 3'h5 |-> ##4 second_word) else $error("second word not taken");
  skip_slot_a: assert property (
    issue && cost == 2'h2 && instr_class != 3'h5 |-> ##4 nop_slot) else $error("nop slot missing");
  branch_three_a: assert property (
    issue && cost == 2'h3 |-> ##4 second_word ##4 nop_slot) else $error("taken double timing wrong");
  single_cost_a: assert property (
    issue && cost == 2'h1 |=> !nop_slot [*4]) else $error("nop after single cycle op");
  phase_align_a: assert property (
    cycle_strobe |-> q_phase == 2'h3) else $error("phase not aligned to strobe");
  nop_no_fetch_a: assert property (
    nop_slot |-> !fetch_req) else $error("fetch during nop slot");
  fast_call_a: assert property (
    issue && $past(instr_word[15:8]) == 8'hD3 |-> shadow_save == $past(instr_word[0]))
    else $error("fast call save wrong");
  cover property (issue && cost == 2'h3);
  cover property (pready && pslverr);
  cover property (issue && instr_class == 3'h2);
endmodule
`default_nettype wire

// ### sim/tb_instr_decode_timing.sv
// self-checking bench for the instruction decode and timing block
`timescale 1ns/10ps
`default_nettype none
module tb_instr_decode_timing;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, cond_true = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] instr_word = '0;
  logic pready, pslverr, err, issue, second_word, dest_file;
  logic [1:0] cost;
  logic [2:0] instr_class, ext_opcode, bit_sel;
  logic [11:0] data_addr;
  logic [7:0] literal;
  logic [23:0] dw_payload;
  logic shadow_save, shadow_restore, table_access, table_write;
  logic [5:0] base_opcode;
  logic [7:0] branch_offset;
  logic [20:0] table_addr;
  // control and bit tests: word, cond, cost, opcode, {save, restore, table, write}
  logic [15:0] xw [6] = '{16'hD2F0, 16'hD2F0, 16'hD301, 16'hD401, 16'h6A00, 16'hD607};
  logic [5:0] xc = 6'h12;
  int xco [6] = '{1, 2, 2, 2, 2, 1};
  int xop [6] = '{2, 2, 3, 4, 2, 6};
  logic [3:0] xf [6] = '{4'h0, 4'h0, 4'h8, 4'h4, 4'h0, 4'h3};
  int num_errors = 0, n_compared = 0, waited;
  // sequence: word, cond, class, cost and gap since previous take
  logic [15:0] wl [12] = '{16'h06A5, 16'h093C, 16'h4B22, 16'h807E, 16'h3C10, 16'hD140,
    16'hC123, 16'hF456, 16'hCC12, 16'hF345, 16'hF0AB, 16'hE500};
  logic [11:0] cb = 12'h110;
  int ec [12] = '{1, 1, 2, 3, 1, 4, 5, 5, 5, 5, 0, 6};
  int eco [12] = '{1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 1, 1};
  int ew [12] = '{0, 3, 3, 3, 3, 7, 7, 3, 3, 3, 7, 3};
  int tp [4] = '{'h100, 'h101, 'h100, 'h101};
  instr_decode_timing i_instr_decode_timing (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_word, .instr_valid,
    .cond_true, .fetch_req(), .issue, .second_word, .nop_slot(), .cycle_strobe(), .q_phase(),
    .instr_class, .base_opcode, .ext_opcode, .dest_file, .data_addr, .bit_sel, .literal,
    .branch_offset, .dw_payload, .cost, .shadow_save, .shadow_restore,
    .table_access, .table_write, .table_addr);
  initial forever #2 pclk = ~pclk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_of_test;
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a wait that runs out ends the run
  task guard(input int i);
    if (i >= 40) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    guard(i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // valid stays up so the next word follows without a gap
  task run(input logic [15:0] w, input logic c);
    int i;
    instr_word <= w;
    cond_true <= c;
    instr_valid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (issue === 1'b1 || second_word === 1'b1) break;
    end
    guard(i);
    waited = i;
  endtask
  task idle;
    instr_valid <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h004, 32'hFFFF_FFF5);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("bank", 32'h0000_0005, rd);
    apb(1'b1, 12'h014, 32'h1234_5678);
    chk("slverr", 32'h0000_0001, err);
    for (int k = 0; k < 12; k++) begin
      run(wl[k], cb[k]);
      if (k > 0) chk("gap", ew[k], waited);
      chk("class", ec[k], instr_class);
      chk("cost", eco[k], cost);
      if (k == 1) chk("addr", 32'h0000_053C, data_addr);
      if (k == 3) chk("lit", 32'h0000_007E, literal);
      if (k == 7) chk("pair", 32'h0012_3456, dw_payload);
      if (k == 11) chk("ext", 32'h0000_0005, ext_opcode);
    end
    idle();
    apb(1'b1, 12'h000, 32'h0000_0001);
    run(16'hE500, 1'b0);
    chk("ext off", 32'h0000_0000, instr_class);
    idle();
    apb(1'b1, 12'h008, 32'h0000_0100);
    for (int m = 0; m < 4; m++) begin
      run({14'h3540, m[1:0]}, 1'b0);
      idle();
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("tptr", tp[m], rd);
    end
    for (int k = 0; k < 6; k++) begin
      run(xw[k], xc[k]);
      if (k > 0) chk("ctl gap", 4 * xco[k - 1] - 1, waited);
      if (k == 0) chk("offset", 32'h0000_00F0, branch_offset);
      chk("ctl cost", xco[k], cost);
      chk("opcode", xop[k], base_opcode);
      chk("flags", xf[k], {shadow_save, shadow_restore, table_access, table_write});
    end
    chk("taddr", 32'h0000_0102, table_addr);
    end_of_test();
  end
endmodule
bind instr_decode_timing instr_decode_timing_sva i_instr_decode_timing_sva (.pclk, .presetn,
  .psel, .penable, .paddr, .pready, .pslverr, .instr_word, .issue, .fetch_req, .q_phase,
  .shadow_save, .second_word, .nop_slot,
  .cycle_strobe, .instr_class, .dest_file, .data_addr, .bit_sel, .cost);
`default_nettype wire
